// ### flash_prot_pkg.sv
// Constants and types for the flash block erase and protection gate.
// Assumes a word-addressed 32-bit flash array behind a single request port.
// Function
// RL1: Flash array is sixteen kilobytes, one region
// RL2: Erase works on independent one-kilobyte units
// RL3: Erased unit reads back all ones
// RL4: Protection unit spans two erase units
// RL5: Each protection unit: read-only or execute-only
// RL6: Read-only unit refuses erase/program, allows reads
// RL7: Execute-only unit refuses erase and program
// RL8: Execute-only unit serves instruction fetches only
// RL9: Unprotected unit allows every access
package flash_prot_pkg;

  // Array geometry in bytes
  localparam int FLASH_BYTES = 16384;  // Total capacity
  localparam int WORD_BYTES  = 4;      // Bytes per stored word
  localparam int ERASE_BYTES = 1024;   // One erase unit
  localparam int PROT_BYTES  = 2048;   // One protection unit

  // Derived word counts and address widths
  localparam int DW          = 8 * WORD_BYTES;              // Data width
  localparam int WORDS       = FLASH_BYTES / WORD_BYTES;    // Words in the array
  localparam int AW          = $clog2(WORDS);               // Word address width
  localparam int ERASE_WORDS = ERASE_BYTES / WORD_BYTES;    // Words per erase unit
  localparam int EW          = $clog2(ERASE_WORDS);         // Offset inside erase unit
  localparam int N_ERASE     = FLASH_BYTES / ERASE_BYTES;   // Erase units
  localparam int EUW         = $clog2(N_ERASE);             // Erase unit index width
  localparam int N_PROT      = FLASH_BYTES / PROT_BYTES;    // Protection units
  localparam int PUW         = $clog2(N_PROT);              // Protection unit index width

  // Word value left behind by an erase
  localparam logic [DW-1:0] ERASED_WORD = 32'hffffffff;
  // Data returned for a refused read
  localparam logic [DW-1:0] DENIED_WORD = 32'h00000000;

  // Request operations
  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_NONE} op_t;
  // Request sources
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG, SRC_NONE} src_t;
  // Controller states
  typedef enum logic {ST_IDLE, ST_ERASE} state_t;

endpackage : flash_prot_pkg

// ### prot_if.sv
// Interface between the access controller and its protection checker.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface prot_if;
  import flash_prot_pkg::*;
  logic [PUW-1:0] unit;   // Protection unit addressed
  src_t           src;    // Requesting path
  op_t            op;     // Requested operation
  logic           allow;  // Access permitted
  modport req (output unit, output src, output op, input allow);
  modport chk (input unit, input src, input op, output allow);
endinterface : prot_if
`default_nettype wire

// ### prot_check.sv
// Per-unit protection decision for one flash request.
// Assumes attribute masks are steady levels from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module prot_check
  import flash_prot_pkg::*;
#(
  parameter int NP = N_PROT
) (
  // Clock and reset, used by the checks only
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Attributes per protection unit
  input  wire logic [NP-1:0] ro_mask,
  input  wire logic [NP-1:0] xo_mask,
  // Request to judge
  prot_if.chk                p
);

  logic ro_hit;  // Unit is read-only
  logic xo_hit;  // Unit is execute-only

  // Decide whether the request may proceed
  always_comb begin
    ro_hit = ro_mask[p.unit];  // RL4 RL5
    xo_hit = xo_mask[p.unit];  // RL5
    case (p.op)
      // Reads pass unless execute-only and not a fetch
      OP_READ:  p.allow = !xo_hit || (p.src == SRC_FETCH);  // RL8 RL6 RL9
      // Any attribute blocks modification
      OP_PROG,
      OP_ERASE: p.allow = !(ro_hit || xo_hit);  // RL6 RL7 RL9
      default:  p.allow = 1'b0;
    endcase
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  ro_mod_block_a: assert property ((p.op inside {OP_PROG, OP_ERASE}) && ro_mask[p.unit]
                                   |-> !p.allow)  // RL6
    else $error("read-only unit allowed a modification");
  xo_mod_block_a: assert property ((p.op inside {OP_PROG, OP_ERASE}) && xo_mask[p.unit]
                                   |-> !p.allow)  // RL7
    else $error("execute-only unit allowed a modification");

endmodule : prot_check
`default_nettype wire

// ### flash_block_erase_protect.sv
// Flash array with block erase and per-pair read-only / execute-only protection.
// Assumes requests come from logic on sys_clk and hold while req_ready is low.
`timescale 1ns/10ps
`default_nettype none
module flash_block_erase_protect
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Protection attributes, one bit per protection unit
  input  wire logic [N_PROT-1:0] prot_ro,
  input  wire logic [N_PROT-1:0] prot_xo,
  // Request
  input  wire logic          req_valid,
  input  wire op_t           req_op,
  input  wire src_t          req_src,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               req_ready,
  // Response
  output logic               resp_valid,
  output logic               resp_denied,
  output logic [DW-1:0]      resp_rdata
);

  localparam logic [EW-1:0] ECNT_LAST = EW'(ERASE_WORDS - 1);  // Final erase offset
  // Take-to-answer for erase: the answer is registered on the same edge as the last word's write,
  // so a read taken with the answer already sees that last word erased
  localparam int            ERASE_DLY = ERASE_WORDS + 1;

  logic [DW-1:0] mem [WORDS];  // RL1 Flash storage

  // Registers
  state_t         state_ff;        // Controller state
  logic           ready_ff;        // Ready to take a request
  logic           resp_valid_ff;   // Answer strobe
  logic           resp_denied_ff;  // Answer was a refusal
  logic [DW-1:0]  rdata_ff;        // Read data
  logic [EW-1:0]  ecnt_ff;         // Word offset while erasing
  logic [EUW-1:0] eunit_ff;        // Erase unit being erased

  // Next values
  state_t         nxt_state;
  logic           nxt_ready;
  logic           nxt_resp_valid;
  logic           nxt_resp_denied;
  logic [DW-1:0]  nxt_rdata;
  logic [EW-1:0]  nxt_ecnt;
  logic [EUW-1:0] nxt_eunit;

  // Memory write port
  logic           mem_we;
  logic [AW-1:0]  mem_waddr;
  logic [DW-1:0]  mem_wdata;

  logic           take;  // Request accepted this cycle

  prot_if pif ();

  // Protection decision for the incoming request
  prot_check #(.NP(N_PROT)) u_check (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ro_mask (prot_ro),
    .xo_mask (prot_xo),
    .p       (pif)
  );

  // Route the request to the checker
  always_comb begin
    pif.unit = req_addr[AW-1 -: PUW];  // RL4
    pif.src  = req_src;
    pif.op   = req_op;
  end

  // Request handling and erase sequencing
  always_comb begin
    take            = req_valid && ready_ff;
    nxt_state       = state_ff;
    nxt_resp_valid  = 1'b0;
    nxt_resp_denied = 1'b0;
    nxt_rdata       = rdata_ff;
    nxt_ecnt        = ecnt_ff;
    nxt_eunit       = eunit_ff;
    mem_we          = 1'b0;
    mem_waddr       = req_addr;
    mem_wdata       = mem[req_addr] & req_wdata;  // Programming only clears bits
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          case (req_op)
            // Read returns data, or zeros when refused
            OP_READ: begin
              nxt_resp_valid  = 1'b1;
              nxt_resp_denied = !pif.allow;  // RL8
              nxt_rdata       = pif.allow ? mem[req_addr] : DENIED_WORD;  // RL1
            end
            // Program writes the word in place when allowed
            OP_PROG: begin
              nxt_resp_valid  = 1'b1;
              nxt_resp_denied = !pif.allow;  // RL6 RL7
              mem_we          = pif.allow;  // RL9
            end
            // Erase starts the word walk when allowed
            OP_ERASE: begin
              if (pif.allow) begin
                nxt_state = ST_ERASE;
                nxt_ecnt  = '0;
                nxt_eunit = req_addr[AW-1 -: EUW];  // RL2
              end else begin
                nxt_resp_valid  = 1'b1;
                nxt_resp_denied = 1'b1;  // RL6 RL7
              end
            end
            // Unknown operation is refused
            default: begin
              nxt_resp_valid  = 1'b1;
              nxt_resp_denied = 1'b1;
            end
          endcase
        end
      end
      // Fill one erase unit with ones, one word per cycle
      ST_ERASE: begin
        mem_we    = 1'b1;
        mem_waddr = {eunit_ff, ecnt_ff};  // RL2
        mem_wdata = ERASED_WORD;  // RL3
        nxt_ecnt  = ecnt_ff + EW'(1);
        if (ecnt_ff == ECNT_LAST) begin
          nxt_state      = ST_IDLE;
          nxt_resp_valid = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_ready = (nxt_state == ST_IDLE);
  end

  // Register the controller state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff       <= ST_IDLE;
      ready_ff       <= 1'b0;
      resp_valid_ff  <= 1'b0;
      resp_denied_ff <= 1'b0;
      rdata_ff       <= '0;
      ecnt_ff        <= '0;
      eunit_ff       <= '0;
    end else begin
      state_ff       <= nxt_state;
      ready_ff       <= nxt_ready;
      resp_valid_ff  <= nxt_resp_valid;
      resp_denied_ff <= nxt_resp_denied;
      rdata_ff       <= nxt_rdata;
      ecnt_ff        <= nxt_ecnt;
      eunit_ff       <= nxt_eunit;
    end
  end

  // Storage write; the array itself carries no reset
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready   = ready_ff;
  assign resp_valid  = resp_valid_ff;
  assign resp_denied = resp_denied_ff;
  assign resp_rdata  = rdata_ff;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic [PUW-1:0] req_unit;  // Protection unit of the request
  assign req_unit = req_addr[AW-1 -: PUW];

  erase_latency_a: assert property (take && req_op == OP_ERASE && !prot_ro[req_unit]
                                    && !prot_xo[req_unit]
                                    |-> ##ERASE_DLY resp_valid_ff && !resp_denied_ff)  // RL2
    else $error("erase answer not on time");
  erase_start_a: assert property ($rose(state_ff == ST_ERASE) |-> ecnt_ff == '0
                                  && !ready_ff)  // RL2
    else $error("erase did not start at unit base");
  erase_ones_a: assert property (state_ff == ST_ERASE ##1 state_ff == ST_IDLE
                                 |-> mem[{eunit_ff, EW'(0)}] == ERASED_WORD
                                 && mem[{eunit_ff, ECNT_LAST}] == ERASED_WORD)  // RL3
    else $error("erased unit not all ones");
  ro_refuse_a: assert property (take && req_op inside {OP_PROG, OP_ERASE} && prot_ro[req_unit]
                                |=> resp_valid_ff && resp_denied_ff && ready_ff)  // RL6
    else $error("read-only unit modified");
  ro_read_a: assert property (take && req_op == OP_READ && prot_ro[req_unit]
                              && !prot_xo[req_unit] |=> resp_valid_ff && !resp_denied_ff)  // RL6
    else $error("read-only unit refused a read");
  xo_refuse_a: assert property (take && req_op inside {OP_PROG, OP_ERASE} && prot_xo[req_unit]
                                |=> resp_denied_ff)  // RL7
    else $error("execute-only unit modified");
  xo_data_a: assert property (take && req_op == OP_READ && req_src != SRC_FETCH
                              && prot_xo[req_unit]
                              |=> resp_denied_ff && resp_rdata == DENIED_WORD)  // RL8
    else $error("execute-only data read served");
  xo_fetch_a: assert property (take && req_op == OP_READ && req_src == SRC_FETCH
                               |=> resp_valid_ff && !resp_denied_ff)  // RL8
    else $error("instruction fetch refused");
  open_ok_a: assert property (take && req_op inside {OP_READ, OP_PROG}
                              && !prot_ro[req_unit] && !prot_xo[req_unit]
                              |=> resp_valid_ff && !resp_denied_ff)  // RL9
    else $error("unprotected access refused");

  erase_done_c: cover property (state_ff == ST_ERASE ##1 resp_valid_ff);
  xo_deny_c: cover property (take && req_op == OP_READ && prot_xo[req_unit]
                             && req_src == SRC_DEBUG);
  prog_ok_c: cover property (take && req_op == OP_PROG ##1 !resp_denied_ff);

endmodule : flash_block_erase_protect
`default_nettype wire

// ### access_source_model.sv
// Behavioural requester standing for instruction fetch, data path and debugger.
// Assumes the gate on sys_clk; fields change 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module access_source_model
  import flash_prot_pkg::*;
(
  // Clock
  input  wire logic          sys_clk,
  // Request side
  output var  logic          req_valid,
  output var  op_t           req_op,
  output var  src_t          req_src,
  output var  logic [AW-1:0] req_addr,
  output var  logic [DW-1:0] req_wdata,
  input  wire logic          req_ready,
  // Response side
  input  wire logic          resp_valid,
  input  wire logic          resp_denied,
  input  wire logic [DW-1:0] resp_rdata
);
  // Idle lines show no stale request
  initial begin
    req_valid = 1'b0;
    req_op    = OP_NONE;
    req_src   = SRC_NONE;
    req_addr  = '0;
    req_wdata = '0;
  end

  // One request, held until taken; lat counts cycles to the answer, -1 on a hang
  task automatic xfer(input op_t o, input src_t s, input logic [AW-1:0] a,
                      input logic [DW-1:0] w, output logic den,
                      output logic [DW-1:0] rd, output int lat);
    int wait_n;
    wait_n = 0;
    lat = -1;
    req_valid = 1'b1;
    req_op    = o;
    req_src   = s;
    req_addr  = a;
    req_wdata = w;
    while (req_ready !== 1'b1 && wait_n < 400) begin
      @(posedge sys_clk);
      #1;
      wait_n++;
    end
    if (wait_n >= 400) return;
    @(posedge sys_clk);
    #1;
    // Released fields flip so a late sample cannot pass by luck
    req_valid = 1'b0;
    req_op    = OP_NONE;
    req_src   = SRC_NONE;
    req_addr  = ~a;
    req_wdata = ~w;
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 400) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    if (lat >= 400) lat = -1;
    den = resp_denied;
    rd  = resp_rdata;
  endtask : xfer
endmodule : access_source_model
`default_nettype wire

// ### flash_block_erase_protect_tb.sv
// Self-checking bench for the flash erase and protection gate.
// Assumes the requester model drives all request inputs.
`timescale 1ns/10ps
`default_nettype none
module flash_block_erase_protect_tb;
  import flash_prot_pkg::*;
  logic              sys_clk = 1'b0;   // 125 MHz clock
  logic              nrst = 1'b0;      // Active-low reset
  logic [N_PROT-1:0] prot_ro = '0;     // Read-only attributes
  logic [N_PROT-1:0] prot_xo = '0;     // Execute-only attributes
  logic              req_valid, req_ready, resp_valid, resp_denied;
  op_t               req_op;
  src_t              req_src;
  logic [AW-1:0]     req_addr;
  logic [DW-1:0]     req_wdata, resp_rdata;
  int                mismatches = 0;   // Failed comparisons
  int                checked = 0;      // All comparisons

  always #4 sys_clk = ~sys_clk;

  flash_block_erase_protect dut (.sys_clk(sys_clk), .nrst(nrst), .prot_ro(prot_ro),
    .prot_xo(prot_xo), .req_valid(req_valid), .req_op(req_op), .req_src(req_src),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_denied(resp_denied), .resp_rdata(resp_rdata));

  access_source_model host (.sys_clk(sys_clk), .req_valid(req_valid), .req_op(req_op),
    .req_src(req_src), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_denied(resp_denied), .resp_rdata(resp_rdata));

  // Verdict and end of run
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // Compare one value, four-state exact
  task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Issue one request and judge refusal, latency and optionally read data
  task automatic op(input op_t o, input src_t s, input logic [AW-1:0] a, input logic [DW-1:0] w,
                    input logic exp_den, input bit chk_rd, input logic [DW-1:0] exp_rd);
    logic          den;
    logic [DW-1:0] rd;
    int            lat;
    host.xfer(o, s, a, w, den, rd, lat);
    if (lat < 0) begin
      mismatches++;
      $display("MISMATCH handshake expected answer seen hang");
      wrap_up();
    end
    check("denied", {31'h0, den}, {31'h0, exp_den});
    // Allowed erase answers on the same edge that writes its last word
    check("latency", lat, (o == OP_ERASE && !exp_den) ? ERASE_WORDS + 1 : 32'h1);
    if (chk_rd) check("rdata", rd, exp_rd);
  endtask : op

  // Erase leaves ones; unprotected unit takes every kind of access
  task automatic sc_erase_basic;
    op(OP_ERASE, SRC_FETCH, 12'h000, '0, 1'b0, 0, '0);
    op(OP_READ, SRC_DATA, 12'h000, '0, 1'b0, 1, ERASED_WORD);
    op(OP_READ, SRC_DATA, 12'h0ff, '0, 1'b0, 1, ERASED_WORD);
    op(OP_PROG, SRC_DEBUG, 12'h005, 32'h12345678, 1'b0, 0, '0);
    op(OP_READ, SRC_DEBUG, 12'h005, '0, 1'b0, 1, 32'h12345678);
    op(OP_READ, SRC_FETCH, 12'h005, '0, 1'b0, 1, 32'h12345678);
  endtask : sc_erase_basic

  // Erasing one unit leaves its neighbour alone
  task automatic sc_independent;
    op(OP_ERASE, SRC_DATA, 12'h1c0, '0, 1'b0, 0, '0);
    op(OP_PROG, SRC_DATA, 12'h100, 32'ha5a5a5a5, 1'b0, 0, '0);
    op(OP_ERASE, SRC_DATA, 12'h0ff, '0, 1'b0, 0, '0);
    op(OP_READ, SRC_DATA, 12'h100, '0, 1'b0, 1, 32'ha5a5a5a5);
    op(OP_READ, SRC_DATA, 12'h005, '0, 1'b0, 1, ERASED_WORD);
  endtask : sc_independent

  // Read-only pair: both halves refuse changes, reads still served
  task automatic sc_read_only;
    op(OP_ERASE, SRC_DATA, 12'h200, '0, 1'b0, 0, '0);
    op(OP_ERASE, SRC_DATA, 12'h300, '0, 1'b0, 0, '0);
    op(OP_PROG, SRC_DATA, 12'h3ff, 32'h0f0f0f0f, 1'b0, 0, '0);
    prot_ro = 8'h02;
    op(OP_PROG, SRC_DATA, 12'h200, 32'h0, 1'b1, 0, '0);
    op(OP_ERASE, SRC_DEBUG, 12'h3ff, '0, 1'b1, 0, '0);
    op(OP_READ, SRC_DEBUG, 12'h3ff, '0, 1'b0, 1, 32'h0f0f0f0f);
    op(OP_READ, SRC_DATA, 12'h200, '0, 1'b0, 1, ERASED_WORD);
    op(OP_PROG, SRC_DATA, 12'h100, 32'hffff0000, 1'b0, 0, '0);
    op(OP_READ, SRC_DATA, 12'h100, '0, 1'b0, 1, 32'ha5a50000);
    prot_ro = 8'h00;
  endtask : sc_read_only

  // Execute-only pair: fetch only, no changes
  task automatic sc_exec_only;
    prot_xo = 8'h02;
    op(OP_READ, SRC_FETCH, 12'h3ff, '0, 1'b0, 1, 32'h0f0f0f0f);
    op(OP_READ, SRC_DATA, 12'h3ff, '0, 1'b1, 1, DENIED_WORD);
    op(OP_READ, SRC_DEBUG, 12'h200, '0, 1'b1, 1, DENIED_WORD);
    op(OP_PROG, SRC_FETCH, 12'h3ff, 32'h0, 1'b1, 0, '0);
    op(OP_ERASE, SRC_DEBUG, 12'h200, '0, 1'b1, 0, '0);
    op(OP_READ, SRC_DATA, 12'h100, '0, 1'b0, 1, 32'ha5a50000);
    prot_xo = 8'h00;
    op(OP_READ, SRC_DATA, 12'h3ff, '0, 1'b0, 1, 32'h0f0f0f0f);
  endtask : sc_exec_only

  // Top of the array is reachable; empty operation refused
  task automatic sc_top;
    op(OP_ERASE, SRC_DEBUG, 12'hf00, '0, 1'b0, 0, '0);
    op(OP_READ, SRC_FETCH, 12'hfff, '0, 1'b0, 1, ERASED_WORD);
    op(OP_NONE, SRC_DATA, 12'hfff, '0, 1'b1, 0, '0);
  endtask : sc_top

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    sc_erase_basic();
    sc_independent();
    sc_read_only();
    sc_exec_only();
    sc_top();
    wrap_up();
  end
endmodule : flash_block_erase_protect_tb
`default_nettype wire
